// file: rtl/uartp_pkg.sv
package uartp_pkg;
  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] UARTP_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] UARTP_ADDR_DATA   = 8'h04;
  localparam logic [7:0] UARTP_ADDR_BAUD   = 8'h08;
  localparam logic [7:0] UARTP_ADDR_RELOAD = 8'h0C;
  localparam logic [7:0] UARTP_ADDR_STATUS = 8'h10;

  // Control register field positions
  localparam int CTRL_MODE_HI  = 7;
  localparam int CTRL_MODE_LO  = 6;
  localparam int CTRL_FILTER   = 5;
  localparam int CTRL_REN      = 4;
  localparam int CTRL_TX_NINTH = 3;
  localparam int CTRL_RX_NINTH = 2;
  localparam int CTRL_TX_DONE  = 1;
  localparam int CTRL_RX_DONE  = 0;

  // Baud register field positions
  localparam int BAUD_DOUBLER = 0;
  localparam int BAUD_RX_T2   = 1;
  localparam int BAUD_TX_T2   = 2;

  // Reset values
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [2:0]  BAUD_RESET   = 3'h0;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;

  // Cycle counts
  localparam logic [3:0] M0_DIV_LAST   = 4'hB;  // Shift clock is core clock / 12
  localparam logic [3:0] M0_CLK_HIGH   = 4'h6;  // Shift clock rises at this phase
  localparam logic [3:0] M0_SAMPLE     = 4'h5;  // Input sampled just before the rise
  localparam logic [1:0] FIX_DIV_SLOW  = 2'h3;  // 64 cycles per bit over 16 ticks
  localparam logic [1:0] FIX_DIV_FAST  = 2'h1;  // 32 cycles per bit over 16 ticks
  localparam logic [3:0] OVS_LAST      = 4'hF;  // Sixteen ticks per bit
  localparam logic [3:0] OVS_MID       = 4'h7;  // Mid-bit check of the start bit
  localparam logic [3:0] BITS_M0       = 4'h8;
  localparam logic [3:0] BITS_TEN      = 4'hA;
  localparam logic [3:0] BITS_ELEVEN   = 4'hB;
  localparam logic [3:0] RX_SAMP_TEN   = 4'h9;  // Data plus stop
  localparam logic [3:0] RX_SAMP_ELVN  = 4'hA;  // Data plus ninth plus stop

  // Operating modes
  typedef enum logic [1:0] {
    UARTP_M_SHIFT = 2'b00,
    UARTP_M_TEN   = 2'b01,
    UARTP_M_FIXED = 2'b10,
    UARTP_M_VAR   = 2'b11
  } uartp_mode_e;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_WAIT  = 2'b01,
    TX_SHIFT = 2'b10
  } uartp_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_SYNC  = 2'b11
  } uartp_rx_e;
endpackage

// file: rtl/uartp_top.sv
`timescale 1ns/1ps
// Function
// - Ten-bit frame: start, eight LSB-first, stop
// - Ten-bit write loads a one as ninth
// - Transmit done set as stop bit begins
// - Falling edge starts receive; confirm start bit
// - Accept if done clear and filter passes
// - Eleven-bit accept stores ninth bit, sets done
// - Eleven-bit frame adds programmable ninth bit
// - Ninth bit loaded; start at next divide-by-16 rollover
// - Mode bits decode to the four modes
// - Variable eleven-bit mode uses timer clocks
// - Any buffer write starts a transmission
// - Receive start needs enable; shift mode needs done clear
// - Shift mode runs at core clock / 12
// - Fixed mode: clock/64, or /32 doubled
// - Variable modes use timer 1 or 2
// - Timer 1 rate times doubler over 32
// - Timer 2 ticks every two clocks, 16 overflows/bit
// - Timer-2 select bits force baud mode independently
// - Receive buffer separate from transmit register
// - Filter blocks eleven-bit frames with ninth zero
// - Clear select bits choose timer 1 overflows
module uartp_top
(
  input  wire logic        hclk,             // Core clock, 100 MHz
  input  wire logic        hresetn,          // Async reset, active low
  input  wire logic        hsel,             // Slave select
  input  wire logic [31:0] haddr,            // Byte address
  input  wire logic [1:0]  htrans,           // Transfer type
  input  wire logic        hwrite,           // Write when high
  input  wire logic [2:0]  hsize,            // Transfer size
  input  wire logic [31:0] hwdata,           // Write data
  input  wire logic        hready,           // Bus ready in
  output logic             hreadyout,        // Always ready
  output logic             hresp,            // Always OKAY
  output logic [31:0]      hrdata,           // Read data
  input  wire logic        t1_overflow,      // Timer 1 overflow pulse
  input  wire logic        line_input_in,    // Receive line level
  output logic             line_input_out,   // Shift-mode data out
  output logic             line_input_oe,    // Shift-mode data enable
  output logic             line_output_pin   // Transmit line / shift clock
);
  import uartp_pkg::*;
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [2:0]  baud_r, baud_nxt;
  logic [15:0] reload_r, reload_nxt;
  logic [7:0]  rx_buf_r, rx_buf_nxt;
  logic [7:0]  dp_addr_r, dp_addr_nxt;
  logic        dp_wr_r, dp_wr_nxt;
  logic [31:0] hrdata_nxt;
  logic        addr_ok, buf_write, rd_sel;
  uartp_mode_e mode;
  logic        tx_done_set, rx_accept, rx_ninth_val, rx_busy, tx_busy;
  // Mode decode and address phase qualification
  assign mode    = uartp_mode_e'(ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO]);
  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign buf_write = dp_wr_r && (dp_addr_r == UARTP_ADDR_DATA);
  assign rd_sel  = addr_ok && !hwrite;
  // Register file next state; hardware sets win over software clears
  always_comb begin
    ctrl_nxt    = ctrl_r;
    baud_nxt    = baud_r;
    reload_nxt  = reload_r;
    dp_addr_nxt = addr_ok ? haddr[7:0] : dp_addr_r;
    dp_wr_nxt   = addr_ok && hwrite;
    hrdata_nxt  = 32'h0000_0000;
    if (dp_wr_r) begin
      case (dp_addr_r)
        UARTP_ADDR_CTRL: begin
          ctrl_nxt[7:3] = hwdata[7:3];
          ctrl_nxt[CTRL_TX_DONE] = hwdata[CTRL_TX_DONE];
          ctrl_nxt[CTRL_RX_DONE] = hwdata[CTRL_RX_DONE];
        end
        UARTP_ADDR_BAUD:   baud_nxt   = hwdata[2:0];
        UARTP_ADDR_RELOAD: reload_nxt = hwdata[15:0];
        default: ;
      endcase
    end
    if (tx_done_set) ctrl_nxt[CTRL_TX_DONE] = 1'b1;
    if (rx_accept) begin
      ctrl_nxt[CTRL_RX_DONE]  = 1'b1;
      ctrl_nxt[CTRL_RX_NINTH] = rx_ninth_val;
    end
    if (rd_sel) begin
      case (haddr[7:0])
        UARTP_ADDR_CTRL:   hrdata_nxt = {24'h00_0000, ctrl_r};
        UARTP_ADDR_DATA:   hrdata_nxt = {24'h00_0000, rx_buf_r};
        UARTP_ADDR_BAUD:   hrdata_nxt = {29'h0000_0000, baud_r};
        UARTP_ADDR_RELOAD: hrdata_nxt = {16'h0000, reload_r};
        UARTP_ADDR_STATUS: hrdata_nxt = {30'h0000_0000, rx_busy, tx_busy};
        default:           hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  // Register file storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= CTRL_RESET;
      baud_r    <= BAUD_RESET;
      reload_r  <= RELOAD_RESET;
      dp_addr_r <= 8'h00;
      dp_wr_r   <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      baud_r    <= baud_nxt;
      reload_r  <= reload_nxt;
      dp_addr_r <= dp_addr_nxt;
      dp_wr_r   <= dp_wr_nxt;
      hrdata    <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  // Baud tick generation
  logic [3:0]  m0_ph_r, m0_ph_nxt;
  logic [1:0]  fix_r, fix_nxt;
  logic        t1_half_r, t1_half_nxt;
  logic        t2_pre_r, t2_pre_nxt;
  logic [15:0] t2_cnt_r, t2_cnt_nxt;
  logic        m0_shift, m0_sample, fix_tick, t1_tick, t2_run, t2_ovf;
  logic        tx_t16, rx_t16;
  assign m0_shift  = (mode == UARTP_M_SHIFT) && (m0_ph_r == M0_DIV_LAST);
  assign m0_sample = (mode == UARTP_M_SHIFT) && (m0_ph_r == M0_SAMPLE);
  assign fix_tick  = (fix_r == 2'h0);
  assign t1_tick   = t1_overflow && (baud_r[BAUD_DOUBLER] || t1_half_r);
  assign t2_run    = baud_r[BAUD_RX_T2] || baud_r[BAUD_TX_T2];
  assign t2_ovf    = t2_run && t2_pre_r && (t2_cnt_r == 16'hFFFF);
  // Each direction picks its own source; a clear select bit means timer 1
  assign tx_t16 = (mode == UARTP_M_FIXED) ? fix_tick :
                  (baud_r[BAUD_TX_T2] ? t2_ovf : t1_tick);
  assign rx_t16 = (mode == UARTP_M_FIXED) ? fix_tick :
                  (baud_r[BAUD_RX_T2] ? t2_ovf : t1_tick);
  // Dividers and timer 2 counter; a stopped counter holds the reload value
  always_comb begin
    m0_ph_nxt   = (m0_ph_r == M0_DIV_LAST) ? 4'h0 : m0_ph_r + 4'h1;
    fix_nxt     = fix_tick ? (baud_r[BAUD_DOUBLER] ? FIX_DIV_FAST : FIX_DIV_SLOW)
                           : fix_r - 2'h1;
    t1_half_nxt = t1_overflow ? !t1_half_r : t1_half_r;
    t2_pre_nxt  = t2_run ? !t2_pre_r : 1'b0;
    t2_cnt_nxt  = t2_run ? t2_cnt_r : reload_r;
    if (t2_run && t2_pre_r) begin
      t2_cnt_nxt = t2_ovf ? reload_r : t2_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m0_ph_r   <= 4'h0;
      fix_r     <= 2'h0;
      t1_half_r <= 1'b0;
      t2_pre_r  <= 1'b0;
      t2_cnt_r  <= 16'h0000;
    end else begin
      m0_ph_r   <= m0_ph_nxt;
      fix_r     <= fix_nxt;
      t1_half_r <= t1_half_nxt;
      t2_pre_r  <= t2_pre_nxt;
      t2_cnt_r  <= t2_cnt_nxt;
    end
  end
  // Transmitter
  uartp_tx_e   tx_state_r, tx_state_nxt;
  logic [10:0] tx_sh_r, tx_sh_nxt;
  logic [3:0]  tx_cnt_r, tx_cnt_nxt;
  logic [3:0]  tx_div_r, tx_div_nxt;
  logic        txd_r, txd_nxt, dout_r, dout_nxt, doe_r, doe_nxt;
  logic [3:0]  tx_bits;
  logic        tx_step;
  assign tx_bits = (mode == UARTP_M_SHIFT) ? BITS_M0 :
                   (mode == UARTP_M_TEN) ? BITS_TEN : BITS_ELEVEN;
  assign tx_step = (mode == UARTP_M_SHIFT) ? m0_shift : (tx_t16 && tx_div_r == OVS_LAST);
  assign tx_busy = (tx_state_r != TX_IDLE);
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_sh_nxt    = tx_sh_r;
    tx_cnt_nxt   = tx_cnt_r;
    tx_div_nxt   = tx_t16 ? tx_div_r + 4'h1 : tx_div_r;
    txd_nxt      = txd_r;
    dout_nxt     = dout_r;
    doe_nxt      = doe_r;
    tx_done_set  = 1'b0;
    case (tx_state_r)
      TX_IDLE: begin
        txd_nxt = 1'b1;
        doe_nxt = 1'b0;
      end
      TX_WAIT: begin
        if (tx_step) begin
          tx_state_nxt = TX_SHIFT;
          tx_cnt_nxt   = 4'h1;
          tx_sh_nxt    = {1'b1, tx_sh_r[10:1]};
          if (mode == UARTP_M_SHIFT) begin
            dout_nxt = tx_sh_r[0];
            doe_nxt  = 1'b1;
          end else begin
            txd_nxt = tx_sh_r[0];
          end
        end
      end
      TX_SHIFT: begin
        if (tx_step) begin
          if (tx_cnt_r == tx_bits) begin
            tx_state_nxt = TX_IDLE;
            txd_nxt      = 1'b1;
            doe_nxt      = 1'b0;
            if (mode == UARTP_M_SHIFT) tx_done_set = 1'b1;
          end else begin
            tx_cnt_nxt = tx_cnt_r + 4'h1;
            tx_sh_nxt  = {1'b1, tx_sh_r[10:1]};
            if (mode == UARTP_M_SHIFT) begin
              dout_nxt = tx_sh_r[0];
            end else begin
              txd_nxt = tx_sh_r[0];
            end
            // Stop bit is the last one of the frame
            if (mode != UARTP_M_SHIFT && tx_cnt_r == tx_bits - 4'h1) begin
              tx_done_set = 1'b1;
            end
          end
        end
      end
      default: tx_state_nxt = TX_IDLE;
    endcase
    // A buffer write always (re)loads the frame
    if (buf_write) begin
      tx_state_nxt = TX_WAIT;
      tx_cnt_nxt   = 4'h0;
      case (mode)
        UARTP_M_SHIFT: tx_sh_nxt = {3'b111, hwdata[7:0]};
        UARTP_M_TEN:   tx_sh_nxt = {2'b11, hwdata[7:0], 1'b0};
        default:       tx_sh_nxt = {1'b1, ctrl_r[CTRL_TX_NINTH], hwdata[7:0], 1'b0};
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_r <= TX_IDLE;
      tx_sh_r    <= 11'h7FF;
      tx_cnt_r   <= 4'h0;
      tx_div_r   <= 4'h0;
      txd_r      <= 1'b1;
      dout_r     <= 1'b1;
      doe_r      <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_sh_r    <= tx_sh_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      tx_div_r   <= tx_div_nxt;
      txd_r      <= txd_nxt;
      dout_r     <= dout_nxt;
      doe_r      <= doe_nxt;
    end
  end
  // Receiver
  uartp_rx_e   rx_state_r, rx_state_nxt;
  logic [9:0]  rx_sh_r, rx_sh_nxt;
  logic [3:0]  rx_cnt_r, rx_cnt_nxt;
  logic [3:0]  rx_tk_r, rx_tk_nxt;
  logic        rxd_prev_r;
  logic        sclk_r, sclk_nxt, pin_nxt;
  logic [3:0]  rx_samps;
  logic        rx_final, rx_fall;
  logic [9:0]  rx_frame;
  assign rx_samps = (mode == UARTP_M_TEN) ? RX_SAMP_TEN : RX_SAMP_ELVN;
  assign rx_fall  = rxd_prev_r && !line_input_in;
  assign rx_frame = {line_input_in, rx_sh_r[9:1]};
  assign rx_final = (rx_state_r == RX_DATA) && rx_t16 && (rx_tk_r == OVS_LAST)
                    && (rx_cnt_r == rx_samps - 4'h1);
  // Ten-bit frames keep the stop bit, eleven-bit frames the ninth bit
  assign rx_ninth_val = (mode == UARTP_M_TEN) ? line_input_in : rx_sh_r[9];
  assign rx_busy  = (rx_state_r != RX_IDLE);
  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_sh_nxt    = rx_sh_r;
    rx_cnt_nxt   = rx_cnt_r;
    rx_tk_nxt    = rx_tk_r;
    rx_buf_nxt   = rx_buf_r;
    rx_accept    = 1'b0;
    case (rx_state_r)
      RX_IDLE: begin
        rx_tk_nxt  = 4'h0;
        rx_cnt_nxt = 4'h0;
        if (ctrl_r[CTRL_REN]) begin
          if (mode == UARTP_M_SHIFT) begin
            if (!ctrl_r[CTRL_RX_DONE] && !tx_busy) rx_state_nxt = RX_SYNC;
          end else if (rx_fall) begin
            rx_state_nxt = RX_START;
          end
        end
      end
      RX_START: begin
        if (rx_t16) begin
          rx_tk_nxt = rx_tk_r + 4'h1;
          if (rx_tk_r == OVS_MID) begin
            // A glitch that is high again by mid-bit is no start bit
            rx_state_nxt = line_input_in ? RX_IDLE : RX_DATA;
            rx_tk_nxt    = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (rx_t16) begin
          rx_tk_nxt = rx_tk_r + 4'h1;
          if (rx_tk_r == OVS_LAST) begin
            rx_sh_nxt  = rx_frame;
            rx_cnt_nxt = rx_cnt_r + 4'h1;
            if (rx_final) begin
              rx_state_nxt = RX_IDLE;
              if (!ctrl_r[CTRL_RX_DONE] &&
                  (!ctrl_r[CTRL_FILTER] || rx_ninth_val)) begin
                rx_accept  = 1'b1;
                rx_buf_nxt = (mode == UARTP_M_TEN) ? rx_sh_r[9:2] : rx_sh_r[8:1];
              end
            end
          end
        end
      end
      RX_SYNC: begin
        if (m0_sample) begin
          rx_sh_nxt  = rx_frame;
          rx_cnt_nxt = rx_cnt_r + 4'h1;
          if (rx_cnt_r == BITS_M0 - 4'h1) begin
            rx_state_nxt = RX_IDLE;
            rx_accept    = 1'b1;
            rx_buf_nxt   = rx_frame[9:2];
          end
        end
      end
      default: rx_state_nxt = RX_IDLE;
    endcase
    // Shift clock low for the first half of each 12-cycle bit
    sclk_nxt = !((rx_state_nxt == RX_SYNC || tx_state_nxt == TX_SHIFT) &&
                 mode == UARTP_M_SHIFT && m0_ph_nxt < M0_CLK_HIGH);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_r <= RX_IDLE;
      rx_sh_r    <= 10'h000;
      rx_cnt_r   <= 4'h0;
      rx_tk_r    <= 4'h0;
      rx_buf_r   <= 8'h00;
      rxd_prev_r <= 1'b1;
      sclk_r     <= 1'b1;
      line_output_pin <= 1'b1;
    end else begin
      rx_state_r <= rx_state_nxt;
      rx_sh_r    <= rx_sh_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      rx_tk_r    <= rx_tk_nxt;
      rx_buf_r   <= rx_buf_nxt;
      rxd_prev_r <= line_input_in;
      sclk_r     <= sclk_nxt;
      line_output_pin <= pin_nxt;
    end
  end
  // Pin outputs, all from flip-flops; the line pin mux looks at the next mode
  assign pin_nxt = (uartp_mode_e'(ctrl_nxt[CTRL_MODE_HI:CTRL_MODE_LO]) == UARTP_M_SHIFT) ?
                   sclk_nxt : txd_nxt;
  assign line_input_out  = dout_r;
  assign line_input_oe   = doe_r;
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready/okay");
  chk_tx_load_wait: assert property (buf_write |=> tx_state_r == TX_WAIT)
    else $error("buffer write did not arm transmitter");
  chk_tx_start_low: assert property (tx_state_r == TX_WAIT && tx_step && !buf_write
    && mode != UARTP_M_SHIFT |=> !txd_r) else $error("start bit not low");
  chk_tx_done_stop: assert property (tx_done_set && mode != UARTP_M_SHIFT |=>
    txd_r && ctrl_r[CTRL_TX_DONE]) else $error("done flag not at stop bit");
  chk_rx_accept_flag: assert property (rx_accept |=> ctrl_r[CTRL_RX_DONE])
    else $error("accepted frame did not set done");
  chk_rx_drop_keep: assert property ((rx_final && !rx_accept) |=> $stable(rx_buf_r))
    else $error("discarded frame reached buffer");
  chk_rx_filter: assert property (rx_final && ctrl_r[CTRL_FILTER] && !rx_ninth_val
    |-> !rx_accept) else $error("filter let ninth-zero frame in");
  chk_rx_ren_idle: assert property (rx_state_r == RX_IDLE && !ctrl_r[CTRL_REN] |=>
    rx_state_r == RX_IDLE) else $error("receiver started while disabled");
  chk_fix_slow_div: assert property (mode == UARTP_M_FIXED && !baud_r[BAUD_DOUBLER] &&
    fix_tick |=> !fix_tick [*3] ##1 fix_tick) else $error("fixed divider not four cycles");
  chk_m0_period: assert property ((m0_shift) |-> ##12 (m0_shift || mode != UARTP_M_SHIFT))
    else $error("shift clock period not 12");
  chk_t2_reload: assert property (t2_ovf |=> t2_cnt_r == $past(reload_r))
    else $error("timer 2 did not reload");
  cov_tx_ten: cover property (tx_done_set && mode == UARTP_M_TEN);
  cov_rx_var_accept: cover property (rx_accept && mode == UARTP_M_VAR);
  cov_rx_filtered: cover property (rx_final && !rx_accept && ctrl_r[CTRL_FILTER]);
  cov_rx_shift: cover property (rx_accept && mode == UARTP_M_SHIFT);
endmodule // uartp_top

// file: tb/uartp_remote.sv
`timescale 1ns/1ps
// Remote transceiver on the two data lines; its line idles high between frames
module uartp_remote (
  input  wire logic hclk,     // Core clock, used as the bit timebase
  input  wire logic line_rx,  // Line driven by the device
  output logic      line_tx   // Line driven toward the device
);
  int          rx_per  = 64;  // Clocks per bit when listening
  int          rx_bits = 10;  // Bits after the start bit, stop included
  logic [10:0] rx_word;       // Last frame heard, LSB first
  logic [10:0] sh;            // Listening shift register
  event        got;           // Fires once per frame heard

  initial line_tx = 1'b1;

  // Send a start bit then nb bits of w, LSB first; w carries the stop bit
  task automatic send(input logic [10:0] w, input int nb, input int per);
    line_tx <= 1'b0;
    repeat (per) @(posedge hclk);
    for (int i = 0; i < nb; i++) begin
      line_tx <= w[i];
      repeat (per) @(posedge hclk);
    end
    line_tx <= 1'b1;
  endtask

  // Listen: confirm the start bit at mid-bit, then sample each bit at mid-bit
  always begin
    @(negedge line_rx);
    repeat (rx_per / 2) @(posedge hclk);
    if (line_rx === 1'b0) begin
      sh = '0;
      for (int i = 0; i < rx_bits; i++) begin
        repeat (rx_per) @(posedge hclk);
        sh[i] = line_rx;
      end
      rx_word = sh;
      -> got;
    end
  end
endmodule // uartp_remote

// file: tb/uartp_top_tb.sv
`timescale 1ns/1ps
`define CHK(got_v, exp_v) begin checked++; if ((got_v) !== (exp_v)) begin num_errors++; \
  $display("BAD %0t value %h expected %h", $time, got_v, exp_v); end end
module uartp_top_tb;
  import uartp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, t1_overflow;
  logic [31:0] haddr, hwdata, rd_obs;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  d, d2;
  wire         hreadyout, hresp, line_input_out, line_input_oe, line_output_pin, line_rem;
  wire  [31:0] hrdata;
  wire         line_in = line_input_oe ? line_input_out : line_rem;
  int          num_errors = 0;
  int          checked = 0;
  logic [31:0] rd_q[$];
  logic [10:0] ln_q[$];
  logic [7:0]  zaddr[4] = '{UARTP_ADDR_BAUD, UARTP_ADDR_RELOAD, UARTP_ADDR_STATUS, 8'h20};
  event        rd_seen;

  uartp_top u_uartp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .t1_overflow(t1_overflow),
    .line_input_in(line_in), .line_input_out(line_input_out), .line_input_oe(line_input_oe),
    .line_output_pin(line_output_pin));
  uartp_remote u_uartp_remote (.hclk(hclk), .line_rx(line_output_pin), .line_tx(line_rem));

  // Clock and a timer 1 overflow pulse every second cycle
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    t1_overflow = 1'b0;
    forever @(posedge hclk) t1_overflow <= ~t1_overflow;
  end

  // Verdict and end of run
  task automatic stop_test();
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One AHB-Lite single word transfer, bounded waits on hready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] r);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    if (n >= 100) begin num_errors++; stop_test(); end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    bus(a, 1'b1, v, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    rd_q.push_back(e);
    bus(a, 1'b0, 32'h0, r);
    rd_obs = r;
    -> rd_seen;
  endtask

  // Note the frame the remote should hear, then start it by a buffer write
  task automatic expect_tx(input logic [10:0] e, input int nb, input int per);
    u_uartp_remote.rx_bits = nb;
    u_uartp_remote.rx_per = per;
    ln_q.push_back(e);
    wr(UARTP_ADDR_DATA, {24'h0, e[7:0]});
  endtask

  // Remote sends a frame, then buffer and control are read back
  task automatic rx_frame(input logic [10:0] w, input int nb, input int per,
                          input logic [7:0] de, input logic [31:0] ce);
    u_uartp_remote.send(w, nb, per);
    rd(UARTP_ADDR_DATA, {24'h0, de});
    rd(UARTP_ADDR_CTRL, ce);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (ln_q.size() != 0 && n < 20000) begin @(posedge hclk); n++; end
    if (n >= 20000) begin num_errors++; stop_test(); end
  endtask

  // Result watchers: oldest note against each observed result
  always begin : rd_watch
    logic [31:0] e;
    @(rd_seen);
    e = rd_q.pop_front();
    `CHK(rd_obs, e)
  end
  always begin : line_watch
    logic [10:0] e;
    @(u_uartp_remote.got);
    e = ln_q.pop_front();
    `CHK(u_uartp_remote.rx_word, e)
    `CHK({line_input_oe, line_input_out, hresp}, 3'b010)
  end

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    void'($urandom(32'h7a1fe2ff));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(UARTP_ADDR_CTRL, 32'h0);
    foreach (zaddr[i]) rd(zaddr[i], 32'h0);
    // Fixed rate eleven-bit transmit, slow rate, ninth bit one
    wr(UARTP_ADDR_CTRL, 32'h88);
    d = $urandom;
    expect_tx({3'b011, d}, 10, 64);
    drain();
    rd(UARTP_ADDR_CTRL, 32'h8A);
    // Fixed rate eleven-bit receive, doubled; done-set drop and filter
    wr(UARTP_ADDR_BAUD, 32'h1);
    wr(UARTP_ADDR_CTRL, 32'h90);
    d = $urandom;
    d2 = $urandom;
    rx_frame({3'b011, d}, 10, 32, d, 32'h95);
    rx_frame({3'b011, d2}, 10, 32, d, 32'h95);
    wr(UARTP_ADDR_CTRL, 32'hB0);
    rx_frame({3'b010, d2}, 10, 32, d, 32'hB4);
    rx_frame({3'b011, d2}, 10, 32, d2, 32'hB5);
    // Ten-bit mode on timer 1, undoubled; stop bit filter
    wr(UARTP_ADDR_BAUD, 32'h0);
    wr(UARTP_ADDR_CTRL, 32'h50);
    d = $urandom;
    expect_tx({3'b001, d}, 9, 64);
    drain();
    rd(UARTP_ADDR_CTRL, 32'h56);
    wr(UARTP_ADDR_CTRL, 32'h70);
    rx_frame({3'b000, d}, 9, 64, d2, 32'h74);
    rx_frame({3'b001, d}, 9, 64, d, 32'h75);
    // Variable eleven-bit: transmit on timer 2, receive on timer 1 doubled
    wr(UARTP_ADDR_RELOAD, 32'hFFFE);
    wr(UARTP_ADDR_BAUD, 32'h5);
    wr(UARTP_ADDR_CTRL, 32'hD0);
    d = $urandom;
    d2 = $urandom;
    fork
      expect_tx({3'b010, d}, 10, 64);
      begin
        repeat (3) @(posedge hclk);
        u_uartp_remote.send({3'b011, d2}, 10, 32);
      end
    join
    drain();
    rd(UARTP_ADDR_DATA, {24'h0, d2});
    rd(UARTP_ADDR_CTRL, 32'hD7);
    stop_test();
  end
endmodule // uartp_top_tb
